// ==== dv/tb.sv ====
/*
  self-checking bench of twra_top with a host model on the port.
  assumes a pull-down on the data line.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, resetn, clk_en, p_clk, h_d, h_drv, line;
  logic [4:0] feat_sel;
  logic d_o, oe, enabled, core_rst, commit;
  logic [15:0] feat;
  logic [7:0] q;
  int err_total, checked, commits, core_rsts;
  assign line = oe ? d_o : (h_drv ? h_d : 1'b0);
  twra_host_model twra_host_model_inst (.port_clk_o(p_clk), .data_o(h_d),
    .drive_o(h_drv), .line_i(line));
  twra_top twra_top_inst (.CORE_CLK_I(core_clk), .RESETN_I(resetn),
    .CLK_EN_I(clk_en), .PORT_CLK_I(p_clk), .PORT_DATA_I(line),
    .FEAT_SEL_I(feat_sel), .PORT_DATA_O(d_o), .PORT_DATA_OE_O(oe),
    .PORT_ENABLED_O(enabled), .CORE_RESET_O(core_rst),
    .COMMIT_DONE_O(commit), .FEAT_VALUE_O(feat));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    if (commit === 1'b1) commits++;
    if (core_rst === 1'b1) core_rsts++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    twra_host_model_inst.frame({2'b10, a, d}, 1'b0, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    twra_host_model_inst.frame({2'b11, a, 8'h00}, 1'b1, q);
    check(q, exp);
  endtask
  task automatic sel(input logic [4:0] s, input logic [15:0] exp);
    @(negedge core_clk) feat_sel = s;
    repeat (3) @(negedge core_clk);
    check(feat, exp);
  endtask
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset();
    logic s;
    repeat (4) twra_host_model_inst.cycle(1'b0, 1'b0, s);
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    check({oe, enabled, core_rst, commit}, 16'h0000);
  endtask
  task automatic t_disabled();
    wr(6'h12, 8'h77);
    check(enabled, 16'h0000);
    twra_host_model_inst.resync();
    check(enabled, 16'h0001);
    rd(6'h12, 8'h00);
  endtask
  task automatic t_rw();
    logic [5:0] a[4] = '{6'h12, 6'h00, 6'h3f, 6'h2a};
    logic [7:0] d[4] = '{8'haa, 8'h01, 8'h5c, 8'hc3};
    foreach (a[i]) wr(a[i], d[i]);
    foreach (a[i]) rd(a[i], d[i]);
  endtask
  task automatic t_feat();
    wr(6'h18, 8'h02);
    wr(6'h19, 8'hf6);
    wr(6'h1a, 8'hc3);
    wr(6'h25, 8'h01);
    sel(5'h02, 16'hc3f6);
    wr(6'h18, 8'h15);
    wr(6'h19, 8'h34);
    wr(6'h1a, 8'h12);
    wr(6'h25, 8'h01);
    sel(5'h15, 16'h1234);
    check(16'(commits), 16'h0002);
    wr(6'h18, 8'h16);
    wr(6'h25, 8'h01);
    wr(6'h18, 8'h02);
    wr(6'h25, 8'h02);
    sel(5'h02, 16'hc3f6);
    sel(5'h16, 16'h0000);
    // core state holds while the enable is low
    @(negedge core_clk) clk_en = 1'b0;
    sel(5'h02, 16'h0000);
    clk_en = 1'b1;
    repeat (3) @(negedge core_clk);
    check(feat, 16'hc3f6);
    check(16'(commits), 16'h0002);
    rd(6'h25, 8'h00);
    rd(6'h19, 8'h34);
  endtask
  task automatic t_release();
    twra_host_model_inst.frame(16'h8d02, 1'b0, q);
    check(enabled, 16'h0000);
    wr(6'h12, 8'h55);
    twra_host_model_inst.resync();
    rd(6'h12, 8'haa);
    twra_host_model_inst.frame(16'hbd01, 1'b0, q);
    check(16'(core_rsts), 16'h0001);
    check(enabled, 16'h0001);
  endtask
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    feat_sel = 5'h00;
    t_reset();
    t_disabled();
    t_rw();
    t_feat();
    t_release();
    finish_test();
  end
endmodule

// ==== dv/twra_host_model.sv ====
/*
  host side of the two-wire port: clock, data driver, frames.
  assumes the bench resolves the line from both drivers and a pull-down.
*/
module twra_host_model (
  output logic port_clk_o,
  output logic data_o,
  output logic drive_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    port_clk_o = 1'b0;
    data_o = 1'b0;
    drive_o = 1'b0;
  end
  // one clock; data changes with the rising edge, read at the falling one
  task automatic cycle(input logic b, input logic drv, output logic s);
    port_clk_o = 1'b1;
    data_o = b;
    drive_o = drv;
    #7.5;
    s = line_i;
    port_clk_o = 1'b0;
    #7.5;
  endtask
  task automatic frame(input logic [15:0] w, input bit rd,
                       output logic [7:0] q);
    logic s;
    int i;
    for (i = 15; i >= 8; i--) cycle(w[i], 1'b1, s);
    // clock stands low so the device can fetch the byte across domains
    if (rd) #200;
    for (i = 7; i >= 0; i--) begin
      cycle(w[i], !rd, s);
      q[i] = s;
    end
    drive_o = 1'b0;
    #200;
    // one spare edge lets the device drop its driver
    if (rd) cycle(1'b0, 1'b0, s);
    #200;
  endtask
  task automatic resync();
    logic s;
    logic [7:0] q;
    repeat (32) cycle(1'b0, 1'b1, s);
    frame(16'h8d00, 1'b0, q);
  endtask
endmodule

// ==== dv/twra_top_sva.sv ====
/*
  concurrent checks on the ports of twra_top.
  assumes the bind below; port clock runs only within frames.
*/
module twra_top_sva (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic PORT_CLK_I,
  input wire logic [4:0] FEAT_SEL_I,
  input wire logic PORT_DATA_OE_O,
  input wire logic PORT_ENABLED_O,
  input wire logic CORE_RESET_O,
  input wire logic COMMIT_DONE_O,
  input wire logic [15:0] FEAT_VALUE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  // -------------------------------------------------------------------------
  // core clock domain
  // -------------------------------------------------------------------------
  reset_quiet_a: assert property (@(posedge CORE_CLK_I)
    !RESETN_I |-> !PORT_DATA_OE_O && !PORT_ENABLED_O && !CORE_RESET_O
      && !COMMIT_DONE_O && FEAT_VALUE_O == 16'h0000)
    else $error("outputs active during reset");
  commit_pulse_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) COMMIT_DONE_O |=> !COMMIT_DONE_O)
    else $error("commit pulse longer than one cycle");
  core_pulse_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) CORE_RESET_O |=> !CORE_RESET_O)
    else $error("core reset pulse longer than one cycle");
  pulse_apart_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) COMMIT_DONE_O |-> !CORE_RESET_O)
    else $error("commit and core reset together");
  oe_needs_port_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) PORT_DATA_OE_O |-> PORT_ENABLED_O)
    else $error("line driven while port disabled");
  feat_range_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) $past(FEAT_SEL_I) > 5'h15
      |-> FEAT_VALUE_O == 16'h0000)
    else $error("feature value outside index span");
  // -------------------------------------------------------------------------
  // port clock domain
  // -------------------------------------------------------------------------
  oe_run_a: assert property (@(posedge PORT_CLK_I)
    disable iff (!RESETN_I) $rose(PORT_DATA_OE_O) |-> PORT_DATA_OE_O[*8])
    else $error("read drive shorter than eight clocks");
  oe_span_a: assert property (@(posedge PORT_CLK_I)
    disable iff (!RESETN_I) $fell(PORT_DATA_OE_O) |-> $past(PORT_DATA_OE_O, 8))
    else $error("read drive not eight clocks long");
endmodule
bind twra_top twra_top_sva twra_top_sva_inst (
  .CORE_CLK_I(CORE_CLK_I),
  .RESETN_I(RESETN_I),
  .PORT_CLK_I(PORT_CLK_I),
  .FEAT_SEL_I(FEAT_SEL_I),
  .PORT_DATA_OE_O(PORT_DATA_OE_O),
  .PORT_ENABLED_O(PORT_ENABLED_O),
  .CORE_RESET_O(CORE_RESET_O),
  .COMMIT_DONE_O(COMMIT_DONE_O),
  .FEAT_VALUE_O(FEAT_VALUE_O)
);

// ==== rtl/twra_consts.svh ====
/*
  constants of the two-wire register access block: offsets, frame fields,
  command codes and counts.
  assumes inclusion through its bare name from rtl/ files.
*/
`ifndef TWRA_CONSTS_SVH
`define TWRA_CONSTS_SVH

// ---------------------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------------------
`define TWRA_FRAME_BITS 6'h10
`define TWRA_HDR_BITS 6'h08
`define TWRA_LEAD_POS 15
`define TWRA_DIR_POS 14
`define TWRA_DIR_READ 1'h1
`define TWRA_SYNC_LOW_BITS 6'h20

// ---------------------------------------------------------------------------
// command codes
// ---------------------------------------------------------------------------
`define TWRA_CMD_RESYNC 16'h8d00
`define TWRA_CMD_RELEASE 16'h8d02
`define TWRA_CMD_CORE_RST 16'hbd01

// ---------------------------------------------------------------------------
// byte register map
// ---------------------------------------------------------------------------
`define TWRA_OFF_FEAT_INDEX 6'h18
`define TWRA_OFF_FEAT_LOW 6'h19
`define TWRA_OFF_FEAT_HIGH 6'h1a
`define TWRA_OFF_FEAT_COMMIT 6'h25
`define TWRA_COMMIT_VALUE 8'h01
`define TWRA_FEAT_LAST 5'h15
`define TWRA_BYTE_RESET 8'h00
`define TWRA_FEAT_RESET 16'h0000

`endif

// ==== rtl/twra_pkg.sv ====
/*
  types shared by the two-wire register access block.
  assumes twra_consts.svh on the include path.
*/
package twra_pkg;
  typedef enum logic [1:0] {
    TWRA_ST_IDLE = 2'b00,
    TWRA_ST_HEAD = 2'b01,
    TWRA_ST_WDATA = 2'b10,
    TWRA_ST_RDATA = 2'b11
  } twra_state_e;
endpackage

// ==== rtl/twra_regfile.sv ====
/*
  64-byte register space plus 22 sixteen-bit feature registers.
  assumes single-cycle write strobes in the core clock domain; read data
  comes out of a register one cycle after the read strobe.
*/
`include "twra_consts.svh"
module twra_regfile
  import twra_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [4:0] feat_sel_i,
  output logic [7:0] rdata_o,
  output logic [15:0] feat_o,
  output logic commit_o
);
  typedef struct packed {
    logic [63:0][7:0] bytes;
    logic [21:0][15:0] feat;
    logic [7:0] rdata;
    logic commit;
  } twra_rf_s;
  twra_rf_s s_reg;
  twra_rf_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.commit = 1'b0;
    if (en_i) begin
      if (wr_i) begin
        // commit only triggers; it is not stored
        if (addr_i == `TWRA_OFF_FEAT_COMMIT) begin
          if (wdata_i == `TWRA_COMMIT_VALUE) begin
            if (s_reg.bytes[`TWRA_OFF_FEAT_INDEX][7:5] == 3'h0 &&
                s_reg.bytes[`TWRA_OFF_FEAT_INDEX][4:0] <=
                `TWRA_FEAT_LAST) begin
              s_next.feat[s_reg.bytes[`TWRA_OFF_FEAT_INDEX][4:0]] =
                {s_reg.bytes[`TWRA_OFF_FEAT_HIGH],
                 s_reg.bytes[`TWRA_OFF_FEAT_LOW]};
              s_next.commit = 1'b1;
            end
          end
        end else begin
          s_next.bytes[addr_i] = wdata_i;
        end
      end
      if (rd_i) begin
        s_next.rdata = s_reg.bytes[addr_i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign feat_o = (feat_sel_i <= `TWRA_FEAT_LAST) ? s_reg.feat[feat_sel_i] :
                  `TWRA_FEAT_RESET;
  assign commit_o = s_reg.commit;
endmodule

// ==== rtl/twra_sync.sv ====
/*
  two flip-flop level synchroniser.
  assumes an asynchronous input and an active low asynchronous reset.
*/
module twra_sync
  import twra_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } twra_sync_s;
  twra_sync_s s_reg;
  twra_sync_s s_next;

  always_comb begin
    s_next = s_reg;
    if (en_i) begin
      s_next.meta = d_i;
      s_next.sync = s_reg.meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.sync;
endmodule

// ==== rtl/twra_top.sv ====
/*
  slave of the two-wire port: frame decoding on the port clock, register
  space and feature registers on the core clock.
  assumes the host drives PORT_CLK_I only during frames and changes data on
  its rising edge; the data line pin is resolved outside from the enable.
*/
// Functional notes
// - normal frames span sixteen clocks
// - first eight clocks carry header inward
// - last eight: input write, output read
// - direction bit one reads, zero writes
// - six index bits decode 0x00-0x3F
// - write stores byte, read returns byte
// - read drives data line last eight
// - line returns idle after frame
// - resync uses its own special sequence
// - feature index written at 0x18
// - low stage 0x19, high stage 0x1A
// - writing 0x1 to 0x25 commits feature
// - feature indices 0x00 through 0x15 accepted
// - host changes rising, device samples falling
// - resync: 32 low then 0x8D00
// - release 0x8D02 disables port
// - core reset 0xBD01 resets core
`include "twra_consts.svh"
module twra_top
  import twra_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic CLK_EN_I,
  input wire logic PORT_CLK_I,
  input wire logic PORT_DATA_I,
  input wire logic [4:0] FEAT_SEL_I,
  output logic PORT_DATA_O,
  output logic PORT_DATA_OE_O,
  output logic PORT_ENABLED_O,
  output logic CORE_RESET_O,
  output logic COMMIT_DONE_O,
  output logic [15:0] FEAT_VALUE_O
);
  // -------------------------------------------------------------------------
  // port clock domain
  // -------------------------------------------------------------------------
  // the enable is brought across so that port state freezes with the core
  logic en_link;
  twra_sync u_en_sync (
    .clk_i(PORT_CLK_I),
    .rst_n_i(RESETN_I),
    .en_i(1'b1),
    .d_i(CLK_EN_I),
    .q_o(en_link)
  );

  // the port wakes up disabled: only the resync sequence opens it, and a
  // release closes it again
  typedef struct packed {
    twra_state_e state;
    logic [4:0] cnt;
    logic [5:0] low_run;
    logic sync_armed;
    logic enabled;
    logic [15:0] shift;
    logic req_tgl;
    logic req_write;
    logic [5:0] req_addr;
    logic [7:0] req_data;
    logic crst_tgl;
  } twra_fall_s;
  twra_fall_s f_reg;
  twra_fall_s f_next;

  typedef struct packed {
    logic oe;
    logic dout;
    logic [7:0] rd_shift;
  } twra_rise_s;
  twra_rise_s r_reg;
  twra_rise_s r_next;

  logic [15:0] frame_word;
  logic [7:0] rd_byte_core;

  assign frame_word = {f_reg.shift[14:0], PORT_DATA_I};

  // sampling happens on falling edges
  always_comb begin
    f_next = f_reg;
    if (en_link) begin
      f_next.shift = frame_word;
      // a long low run arms resync regardless of framing
      if (PORT_DATA_I) begin
        f_next.low_run = 6'h00;
      end else if (f_reg.low_run != `TWRA_SYNC_LOW_BITS) begin
        f_next.low_run = f_reg.low_run + 6'h01;
      end
      if (f_reg.low_run == `TWRA_SYNC_LOW_BITS && PORT_DATA_I) begin
        f_next.sync_armed = 1'b1;
        f_next.state = TWRA_ST_HEAD;
        f_next.cnt = 5'h01;
      end else begin
        case (f_reg.state)
          TWRA_ST_IDLE: begin
            // outside a resync, a frame opens only on a sampled one while the port is open
            if (PORT_DATA_I && f_reg.enabled) begin
              f_next.state = TWRA_ST_HEAD;
              f_next.cnt = 5'h01;
            end
          end
          TWRA_ST_HEAD: begin
            f_next.cnt = f_reg.cnt + 5'h01;
            if (f_reg.cnt == 5'(`TWRA_HDR_BITS - 6'h01)) begin
              // the byte is fetched now so it is ready by the first data edge
              if (frame_word[6] == `TWRA_DIR_READ && !f_reg.sync_armed &&
                  frame_word[7:0] != 8'(`TWRA_CMD_RESYNC >> 8) &&
                  frame_word[7:0] != 8'(`TWRA_CMD_CORE_RST >> 8)) begin
                f_next.state = TWRA_ST_RDATA;
                f_next.req_write = 1'b0;
                f_next.req_addr = frame_word[5:0];
                f_next.req_tgl = ~f_reg.req_tgl;
              end else begin
                f_next.state = TWRA_ST_WDATA;
              end
            end
          end
          TWRA_ST_WDATA: begin
            f_next.cnt = f_reg.cnt + 5'h01;
            if (f_reg.cnt == 5'(`TWRA_FRAME_BITS - 6'h01)) begin
              f_next.state = TWRA_ST_IDLE;
              f_next.cnt = 5'h00;
              // release and core reset codes are never stored; 0x8D00 is stored as a write unless resync is armed
              if (frame_word == `TWRA_CMD_RESYNC && f_reg.sync_armed) begin
                f_next.enabled = 1'b1;
              end else if (frame_word == `TWRA_CMD_RELEASE) begin
                f_next.enabled = 1'b0;
              end else if (frame_word == `TWRA_CMD_CORE_RST) begin
                f_next.crst_tgl = ~f_reg.crst_tgl;
              end else if (!f_reg.sync_armed) begin
                f_next.req_write = 1'b1;
                f_next.req_addr = frame_word[13:8];
                f_next.req_data = frame_word[7:0];
                f_next.req_tgl = ~f_reg.req_tgl;
              end
              f_next.sync_armed = 1'b0;
            end
          end
          TWRA_ST_RDATA: begin
            f_next.cnt = f_reg.cnt + 5'h01;
            if (f_reg.cnt == 5'(`TWRA_FRAME_BITS - 6'h01)) begin
              f_next.state = TWRA_ST_IDLE;
              f_next.cnt = 5'h00;
            end
          end
          default: begin
            f_next.state = TWRA_ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(negedge PORT_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  // drive happens on rising edges
  // the driver lets go at the first rising edge after the frame, so a host
  // that stops the clock at once leaves it on until its next edge
  always_comb begin
    r_next = r_reg;
    if (en_link) begin
      if (f_reg.state == TWRA_ST_RDATA) begin
        r_next.oe = 1'b1;
        // first data edge: load the fetched byte, its msb leaves at once
        if (!r_reg.oe) begin
          r_next.dout = rd_byte_core[7];
          r_next.rd_shift = {rd_byte_core[6:0], 1'b0};
        end else begin
          r_next.dout = r_reg.rd_shift[7];
          r_next.rd_shift = {r_reg.rd_shift[6:0], 1'b0};
        end
      end else begin
        r_next.oe = 1'b0;
        r_next.dout = 1'b0;
      end
    end
  end

  always_ff @(posedge PORT_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // -------------------------------------------------------------------------
  // core clock domain
  // -------------------------------------------------------------------------
  // the toggle crosses first; the request fields are stable by then because
  // they change on the same port clock edge as the toggle and are not touched until the
  // next frame, many core cycles later
  logic req_tgl_sync;
  logic crst_tgl_sync;
  logic en_sync;
  twra_sync u_req_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .en_i(CLK_EN_I),
    .d_i(f_reg.req_tgl),
    .q_o(req_tgl_sync)
  );
  twra_sync u_crst_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .en_i(CLK_EN_I),
    .d_i(f_reg.crst_tgl),
    .q_o(crst_tgl_sync)
  );
  twra_sync u_ena_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .en_i(CLK_EN_I),
    .d_i(f_reg.enabled),
    .q_o(en_sync)
  );

  // core state other than the register file's commit flag freezes with the enable, so the
  // commit and core reset pulses stretch while it is low; a commit flagged as it drops is lost
  typedef struct packed {
    logic req_seen;
    logic crst_seen;
    logic crst;
    logic enabled;
    logic commit;
    logic [15:0] feat;
  } twra_core_s;
  twra_core_s c_reg;
  twra_core_s c_next;

  logic do_req;
  logic rf_commit;
  logic [15:0] rf_feat;
  assign do_req = CLK_EN_I && (req_tgl_sync != c_reg.req_seen);

  twra_regfile u_regs (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .en_i(CLK_EN_I),
    .wr_i(do_req && f_reg.req_write),
    .rd_i(do_req && !f_reg.req_write),
    .addr_i(f_reg.req_addr),
    .wdata_i(f_reg.req_data),
    .feat_sel_i(FEAT_SEL_I),
    .rdata_o(rd_byte_core),
    .feat_o(rf_feat),
    .commit_o(rf_commit)
  );

  // one pulse per command; the host owes a wait before its next one
  always_comb begin
    c_next = c_reg;
    if (CLK_EN_I) begin
      c_next.req_seen = req_tgl_sync;
      c_next.crst_seen = crst_tgl_sync;
      c_next.crst = crst_tgl_sync != c_reg.crst_seen;
      c_next.enabled = en_sync;
      c_next.commit = rf_commit;
      c_next.feat = rf_feat;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // every output comes straight from a register
  assign PORT_DATA_O = r_reg.dout;
  assign PORT_DATA_OE_O = r_reg.oe;
  assign PORT_ENABLED_O = c_reg.enabled;
  assign CORE_RESET_O = c_reg.crst;
  assign COMMIT_DONE_O = c_reg.commit;
  assign FEAT_VALUE_O = c_reg.feat;
endmodule
